// >>> common/dac_path_pkg.sv
`default_nettype none
package dac_path_pkg;

	// ==========================================================
	// Register map: word indices; the byte address is four times the index.
	// ==========================================================
	localparam logic [7:0] idx_left_vol     = 8'h1e;
	localparam logic [7:0] idx_right_vol    = 8'h1f;
	localparam logic [7:0] idx_sidetone     = 8'h20;
	localparam logic [7:0] idx_path_ctrl    = 8'h21;
	localparam logic [7:0] idx_status       = 8'h22;

	localparam logic [15:0] rst_volume      = 16'h00c0;
	localparam logic [15:0] rst_sidetone    = 16'h0000;
	localparam logic [15:0] rst_path_ctrl   = 16'h0000;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int vu_bit                   = 8;
	localparam int st_left_gain_lsb         = 8;
	localparam int st_right_gain_lsb        = 4;
	localparam int st_left_src_lsb          = 2;
	localparam int st_right_src_lsb         = 0;
	localparam int mono_bit                 = 12;
	localparam int stopband_bit             = 11;
	localparam int ramp_rate_bit            = 10;
	localparam int unmute_ramp_bit          = 9;
	localparam int mute_bit                 = 3;
	localparam int deemphasis_select_lsb               = 1;
	localparam int osr_bit                  = 0;

	// ==========================================================
	// Gain arithmetic
	// ==========================================================
	localparam logic [7:0] gain_code_mute   = 8'h00;
	localparam logic [7:0] gain_code_unity  = 8'hc0;
	localparam logic [8:0] mute_steps       = 9'h0c0;
	localparam logic [3:0] st_code_unity    = 4'hc;
	localparam int st_step_shift            = 3;
	localparam logic [15:0] q15_unity       = 16'h8000;

	// Ramp periods in samples: fs/2 and fs/32.
	localparam logic [4:0] ramp_fast_period = 5'h01;
	localparam logic [4:0] ramp_slow_period = 5'h1f;

	// De-emphasis one-pole coefficients (Q15) for 32k, 44.1k, 48k.
	localparam logic [15:0] deemphasis_select_coef_32  = 16'h5000;
	localparam logic [15:0] deemphasis_select_coef_441 = 16'h5800;
	localparam logic [15:0] deemphasis_select_coef_48  = 16'h5c00;

	typedef enum logic [1:0] {
		src_none  = 2'b00,
		src_left  = 2'b01,
		src_right = 2'b10,
		src_rsvd  = 2'b11
	} st_src_t;

	typedef enum logic [1:0] {
		mute_open    = 2'b00,
		mute_falling = 2'b01,
		mute_closed  = 2'b10,
		mute_rising  = 2'b11
	} mute_state_t;

endpackage
`default_nettype wire

// >>> rtl/dac_digital_volume_mute.sv
// Operation
// R01: Writing the update bit in either volume register applies both pending gains together.
// R02: Gain code 00h mutes, 01h is -71.625dB, 0.375dB steps, C0h and up 0dB.
// R03: Sidetone gain fields at 11:8 and 7:4, -36dB plus 3dB steps, 11XX 0dB.
// R04: Sidetone source 00 none, 01 left ADC, 10 right ADC, 11 reserved.
// R05: Mono bit set outputs the mix of both channels; clear keeps stereo.
// R06: Stopband bit selects normal or sloping stopband interpolation response.
// R07: Mute ramp rate bit selects fs/2 fast or fs/32 slow ramp.
// R08: On unmute, jump straight to gains or ramp up, per the unmute ramp bit.
// R09: Soft mute bit set ramps the signal down to mute; clear leaves it unmuted.
// R10: De-emphasis select 00 off, 01 32kHz, 10 44.1kHz, 11 48kHz.
// R11: Oversample bit selects normal or double oversampling rate.
// R12: Scaled sidetone is added to each channel with saturation to sample width.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

module dac_digital_volume_mute (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [9:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        in_valid,
	input  wire logic [15:0] in_left,
	input  wire logic [15:0] in_right,
	input  wire logic [15:0] adc_left,
	input  wire logic [15:0] adc_right,
	output logic             out_valid,
	output logic      [15:0] out_left,
	output logic      [15:0] out_right,
	output logic             osr_double,
	output logic             sloping_stopband
);

	// ==========================================================
	// Arithmetic helpers
	// ==========================================================
	function automatic logic [15:0] atten_q15(input logic [8:0] k);
		logic [15:0] mant;
		mant = 16'h0000;
		case (k[3:0])
			4'h0: mant = dac_path_pkg::q15_unity;
			4'h1: mant = 16'h7a93;
			4'h2: mant = 16'h7560;
			4'h3: mant = 16'h7066;
			4'h4: mant = 16'h6ba2;
			4'h5: mant = 16'h6712;
			4'h6: mant = 16'h62b4;
			4'h7: mant = 16'h5e84;
			4'h8: mant = 16'h5a82;
			4'h9: mant = 16'h56ac;
			4'ha: mant = 16'h52ff;
			4'hb: mant = 16'h4f7b;
			4'hc: mant = 16'h4c1c;
			4'hd: mant = 16'h48e2;
			4'he: mant = 16'h45cb;
			default: mant = 16'h42d5;
		endcase
		if (k[8]) begin
			atten_q15 = 16'h0000;
		end else begin
			atten_q15 = mant >> k[7:4];
		end
	endfunction

	function automatic logic signed [17:0] scale(input logic signed [17:0] x,
		input logic [15:0] g);
		logic signed [34:0] p;
		p = x * $signed({1'b0, g});
		scale = p[32:15];
	endfunction

	function automatic logic [15:0] sat16(input logic signed [17:0] x);
		if (x > 18'sd32767) begin
			sat16 = 16'h7fff;
		end else if (x < -18'sd32768) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = x[15:0];
		end
	endfunction

	// Volume code to attenuation in 0.375dB steps; bit 8 marks hard mute.
	function automatic logic [8:0] vol_steps(input logic [7:0] code);
		if (code == dac_path_pkg::gain_code_mute) begin
			vol_steps = 9'h100;
		end else if (code >= dac_path_pkg::gain_code_unity) begin
			vol_steps = 9'h000;
		end else begin
			vol_steps = {1'b0, dac_path_pkg::gain_code_unity - code};
		end
	endfunction

	// Each 3dB sidetone step is eight 0.375dB steps.
	function automatic logic [8:0] st_steps(input logic [3:0] code);
		logic [3:0] d;
		d = dac_path_pkg::st_code_unity - code;
		if (code >= dac_path_pkg::st_code_unity) begin
			st_steps = 9'h000; // R03
		end else begin
			st_steps = 9'(d) << dac_path_pkg::st_step_shift; // R03
		end
	endfunction

	function automatic logic signed [17:0] st_pick(input logic [1:0] src,
		input logic [15:0] l, input logic [15:0] r);
		case (src)
			dac_path_pkg::src_left:  st_pick = 18'($signed(l)); // R04
			dac_path_pkg::src_right: st_pick = 18'($signed(r)); // R04
			default:                 st_pick = 18'sd0; // R04
		endcase
	endfunction

	// ==========================================================
	// Register state
	// ==========================================================
	logic [7:0]  pend_left_r;
	logic [7:0]  pend_right_r;
	logic [7:0]  app_left_r;
	logic [7:0]  app_right_r;
	logic [15:0] sidetone_r;
	logic [15:0] path_r;
	logic [8:0]  att_r;
	logic [8:0]  att_nxt;
	logic [4:0]  ramp_cnt_r;
	dac_path_pkg::mute_state_t mute_st_r;
	dac_path_pkg::mute_state_t mute_st_nxt;
	logic signed [17:0] deemphasis_select_left_r;
	logic signed [17:0] deemphasis_select_right_r;
	logic signed [17:0] prev_left_r;
	logic signed [17:0] prev_right_r;

	// ==========================================================
	// APB decode
	// ==========================================================
	wire         acc_done = psel && penable && pready;
	wire         wr_en    = acc_done && pwrite;
	wire [7:0]   word_idx = paddr[9:2];
	wire         hit_lv   = (word_idx == dac_path_pkg::idx_left_vol);
	wire         hit_rv   = (word_idx == dac_path_pkg::idx_right_vol);
	wire         hit_st   = (word_idx == dac_path_pkg::idx_sidetone);
	wire         hit_pc   = (word_idx == dac_path_pkg::idx_path_ctrl);
	wire         hit_sts  = (word_idx == dac_path_pkg::idx_status);
	wire         mapped   = hit_lv || hit_rv || hit_st || hit_pc || hit_sts;
	wire         vu_write = wr_en && (hit_lv || hit_rv) && pwdata[dac_path_pkg::vu_bit];
	wire [7:0]   new_left  = (wr_en && hit_lv) ? pwdata[7:0] : pend_left_r;
	wire [7:0]   new_right = (wr_en && hit_rv) ? pwdata[7:0] : pend_right_r;
	wire [31:0]  rd_mux =
		hit_lv  ? {24'h000000, pend_left_r} :
		hit_rv  ? {24'h000000, pend_right_r} :
		hit_st  ? {16'h0000, sidetone_r} :
		hit_pc  ? {16'h0000, path_r} :
		hit_sts ? {21'h000000, mute_st_r, att_r} : 32'h00000000;

	// ==========================================================
	// Bus slave: one wait state, then pready for a single cycle
	// ==========================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	// Each pending gain updates on any write to its own register; applied gains move only on the update bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_left_r  <= dac_path_pkg::rst_volume[7:0];
			pend_right_r <= dac_path_pkg::rst_volume[7:0];
			app_left_r   <= dac_path_pkg::rst_volume[7:0];
			app_right_r  <= dac_path_pkg::rst_volume[7:0];
			sidetone_r   <= dac_path_pkg::rst_sidetone;
			path_r       <= dac_path_pkg::rst_path_ctrl;
		end else begin
			pend_left_r  <= new_left;
			pend_right_r <= new_right;
			if (vu_write) begin
				app_left_r  <= new_left; // R01
				app_right_r <= new_right; // R01
			end
			if (wr_en && hit_st) begin
				sidetone_r <= {4'h0, pwdata[11:0]};
			end
			if (wr_en && hit_pc) begin
				path_r <= {3'b000, pwdata[12:9], 5'b00000, pwdata[3:0]};
			end
		end
	end

	// ==========================================================
	// Soft mute sequencer
	// ==========================================================
	wire        mute_req   = path_r[dac_path_pkg::mute_bit];
	wire        ramp_up    = path_r[dac_path_pkg::unmute_ramp_bit];
	wire [4:0]  ramp_limit = path_r[dac_path_pkg::ramp_rate_bit] ?
		dac_path_pkg::ramp_slow_period : dac_path_pkg::ramp_fast_period; // R07
	wire        ramp_tick  = in_valid && (ramp_cnt_r == ramp_limit);

	always_comb begin
		mute_st_nxt = mute_st_r;
		att_nxt     = att_r;
		case (mute_st_r)
			dac_path_pkg::mute_open: begin
				if (mute_req) begin
					mute_st_nxt = dac_path_pkg::mute_falling; // R09
				end
			end
			dac_path_pkg::mute_falling: begin
				if (!mute_req) begin
					mute_st_nxt = ramp_up ? dac_path_pkg::mute_rising : dac_path_pkg::mute_open;
					att_nxt     = ramp_up ? att_r : 9'h000; // R08
				end else if (ramp_tick) begin
					att_nxt = att_r + 9'h001; // R09
					if (att_r == dac_path_pkg::mute_steps - 9'h001) begin
						mute_st_nxt = dac_path_pkg::mute_closed;
					end
				end
			end
			dac_path_pkg::mute_closed: begin
				if (!mute_req) begin
					mute_st_nxt = ramp_up ? dac_path_pkg::mute_rising : dac_path_pkg::mute_open;
					att_nxt     = ramp_up ? att_r : 9'h000; // R08
				end
			end
			dac_path_pkg::mute_rising: begin
				if (mute_req) begin
					mute_st_nxt = dac_path_pkg::mute_falling;
				end else if (att_r == 9'h000) begin
					// An unmute before the first ramp tick has nothing to undo; stopping
					// here keeps the step count from wrapping below zero.
					mute_st_nxt = dac_path_pkg::mute_open; // R08
				end else if (ramp_tick) begin
					att_nxt = att_r - 9'h001; // R08
					if (att_r == 9'h001) begin
						mute_st_nxt = dac_path_pkg::mute_open;
					end
				end
			end
			default: begin
				mute_st_nxt = dac_path_pkg::mute_open;
				att_nxt     = 9'h000;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mute_st_r  <= dac_path_pkg::mute_open;
			att_r      <= 9'h000;
			ramp_cnt_r <= 5'h00;
		end else begin
			mute_st_r <= mute_st_nxt;
			att_r     <= att_nxt;
			if (ramp_tick) begin
				ramp_cnt_r <= 5'h00; // R07
			end else if (in_valid) begin
				ramp_cnt_r <= ramp_cnt_r + 5'h01;
			end
		end
	end

	// ==========================================================
	// Sample datapath
	// ==========================================================
	wire [8:0]  k_left   = vol_steps(app_left_r) + att_r; // R02
	wire [8:0]  k_right  = vol_steps(app_right_r) + att_r; // R02
	wire        silenced = (mute_st_r == dac_path_pkg::mute_closed);
	wire [15:0] g_left   = silenced ? 16'h0000 : atten_q15(k_left); // R02
	wire [15:0] g_right  = silenced ? 16'h0000 : atten_q15(k_right); // R02
	wire [3:0]  st_gain_l = sidetone_r[dac_path_pkg::st_left_gain_lsb +: 4];
	wire [3:0]  st_gain_r = sidetone_r[dac_path_pkg::st_right_gain_lsb +: 4];
	wire [1:0]  st_src_l  = sidetone_r[dac_path_pkg::st_left_src_lsb +: 2];
	wire [1:0]  st_src_r  = sidetone_r[dac_path_pkg::st_right_src_lsb +: 2];
	wire [15:0] g_st_l   = atten_q15(st_steps(st_gain_l)); // R03
	wire [15:0] g_st_r   = atten_q15(st_steps(st_gain_r)); // R03

	wire signed [17:0] vol_l = scale(18'($signed(in_left)), g_left);
	wire signed [17:0] vol_r = scale(18'($signed(in_right)), g_right);
	wire signed [17:0] st_l  = scale(st_pick(st_src_l, adc_left, adc_right), g_st_l);
	wire signed [17:0] st_r  = scale(st_pick(st_src_r, adc_left, adc_right), g_st_r);
	wire signed [17:0] mix_l = 18'($signed(sat16(vol_l + st_l))); // R12
	wire signed [17:0] mix_r = 18'($signed(sat16(vol_r + st_r))); // R12

	// Halving the sum keeps the mono mix inside the sample range.
	wire signed [17:0] mono  = (mix_l + mix_r) >>> 1; // R05
	wire        mono_on      = path_r[dac_path_pkg::mono_bit];
	wire signed [17:0] ch_l  = mono_on ? mono : mix_l; // R05
	wire signed [17:0] ch_r  = mono_on ? mono : mix_r; // R05

	// De-emphasis is a one-pole shelf; state tracks the input when disabled.
	wire [1:0]  deemphasis_select_sel = path_r[dac_path_pkg::deemphasis_select_lsb +: 2];
	wire [15:0] de_coef =
		(deemphasis_select_sel == 2'b01) ? dac_path_pkg::deemphasis_select_coef_32 :
		(deemphasis_select_sel == 2'b10) ? dac_path_pkg::deemphasis_select_coef_441 :
		dac_path_pkg::deemphasis_select_coef_48; // R10
	wire signed [17:0] de_l = (deemphasis_select_sel == 2'b00) ? ch_l :
		deemphasis_select_left_r + scale(ch_l - deemphasis_select_left_r, de_coef); // R10
	wire signed [17:0] de_r = (deemphasis_select_sel == 2'b00) ? ch_r :
		deemphasis_select_right_r + scale(ch_r - deemphasis_select_right_r, de_coef); // R10

	// Sloping stopband adds a two-tap average, trading top-octave flatness for rejection.
	wire        sb_on = path_r[dac_path_pkg::stopband_bit];
	wire signed [17:0] fo_l = sb_on ? ((de_l + prev_left_r) >>> 1) : de_l; // R06
	wire signed [17:0] fo_r = sb_on ? ((de_r + prev_right_r) >>> 1) : de_r; // R06

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deemphasis_select_left_r  <= 18'sd0;
			deemphasis_select_right_r <= 18'sd0;
			prev_left_r    <= 18'sd0;
			prev_right_r   <= 18'sd0;
			out_valid      <= 1'b0;
			out_left       <= 16'h0000;
			out_right      <= 16'h0000;
			osr_double     <= 1'b0;
			sloping_stopband <= 1'b0;
		end else begin
			out_valid        <= in_valid;
			osr_double       <= path_r[dac_path_pkg::osr_bit]; // R11
			sloping_stopband <= sb_on; // R06
			if (in_valid) begin
				deemphasis_select_left_r  <= de_l;
				deemphasis_select_right_r <= de_r;
				prev_left_r    <= de_l;
				prev_right_r   <= de_r;
				out_left       <= sat16(fo_l);
				out_right      <= sat16(fo_r);
			end
		end
	end

endmodule

`default_nettype wire

// >>> sim/audio_source.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Sample source standing in for the audio interface
// ==========================================================
module audio_source (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        run,
	input  wire logic [3:0]  gap,
	input  wire logic [15:0] l,
	input  wire logic [15:0] r,
	input  wire logic [15:0] al,
	input  wire logic [15:0] ar,
	output logic             in_valid,
	output logic      [15:0] in_left,
	output logic      [15:0] in_right,
	output logic      [15:0] adc_left,
	output logic      [15:0] adc_right
);
	logic [3:0] cnt_r;
	wire fire = run && cnt_r >= gap;

	// Between samples the data lines toggle, so no stale value can pass as a sample.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 4'h0;
			in_valid <= 1'b0;
			{in_left, in_right, adc_left, adc_right} <= 64'h0;
		end else begin
			cnt_r <= (fire || !run) ? 4'h0 : cnt_r + 4'h1;
			in_valid <= fire;
			if (fire)
				{in_left, in_right, adc_left, adc_right} <= {l, r, al, ar};
			else
				{in_left, in_right, adc_left, adc_right} <= ~{in_left, in_right, adc_left, adc_right};
		end
	end
endmodule
`default_nettype wire

// >>> sim/dvm_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checks for the playback path block
// ==========================================================
module dvm_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [9:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        in_valid,
	input wire logic        out_valid,
	input wire logic [15:0] out_left,
	input wire logic [15:0] out_right,
	input wire logic        osr_double,
	input wire logic        sloping_stopband
);
	wire [7:0] idx = paddr[9:2];
	wire mapped = idx >= dac_path_pkg::idx_left_vol && idx <= dac_path_pkg::idx_status;
	wire ctl_wr = psel && penable && pready && pwrite && idx == dac_path_pkg::idx_path_ctrl;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_decode: assert property (psel && penable && pready |-> pslverr == !mapped)
		else $error("pslverr does not match the decode");
	a_err_rdzero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read data not zero");
	a_rdata_hold: assert property (!$stable(prdata) |-> psel && !pwrite && pready)
		else $error("prdata changed outside a read");
	a_out_valid: assert property (in_valid |=> out_valid)
		else $error("out_valid missing after a sample");
	a_out_hold: assert property (!out_valid |-> $stable(out_left) && $stable(out_right))
		else $error("output samples changed without out_valid");
	a_osr_follow: assert property (ctl_wr |-> ##2 osr_double == $past(pwdata[0], 2))
		else $error("osr_double does not follow the control write");
	a_stopband_follow: assert property (ctl_wr |-> ##2 sloping_stopband == $past(pwdata[11], 2))
		else $error("sloping_stopband does not follow the control write");
endmodule

bind dac_digital_volume_mute dvm_monitor u_mon (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .in_valid(in_valid), .out_valid(out_valid),
	.out_left(out_left), .out_right(out_right), .osr_double(osr_double),
	.sloping_stopband(sloping_stopband));
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Register and sample stream tests
// ==========================================================
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, run, e;
	logic        pready, pslverr, in_valid, out_valid, osr_double, sloping_stopband;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] in_left, in_right, adc_left, adc_right, out_left, out_right, l, r, al, ar;
	logic [3:0]  gap;
	int          error_cnt, samples_checked;

	dac_digital_volume_mute uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
		.adc_left(adc_left), .adc_right(adc_right), .out_valid(out_valid), .out_left(out_left),
		.out_right(out_right), .osr_double(osr_double), .sloping_stopband(sloping_stopband));
	audio_source src (.pclk(pclk), .presetn(presetn), .run(run), .gap(gap), .l(l), .r(r),
		.al(al), .ar(ar), .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
		.adc_left(adc_left), .adc_right(adc_right));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
		samples_checked++;
		if (x !== y) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, x, y);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, i, 2'b00, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		if (n >= 20) chk("pready", 32'h1, 32'h0);
	endtask

	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		apb(1'b1, i, d);
		chk("write error", 32'h0, {31'h0, e});
	endtask

	// The error flag lands in the top bit so one compare covers data and response.
	task automatic rd(input logic [7:0] i, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, i, 32'h0);
		chk("read", x, (q & m) | {e, 31'h0});
	endtask

	task automatic waitn(input int n);
		int k;
		k = 0;
		while (k < n) begin
			@(posedge pclk);
			if (out_valid === 1'b1) k++;
		end
	endtask

	// Three outputs pass so the source has surely launched the new pair.
	task automatic smp(input logic [15:0] il, ir, ial, iar, xl, xr);
		{l, r, al, ar} <= {il, ir, ial, iar};
		waitn(3);
		chk("samples", {xl, xr}, {out_left, out_right});
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#400000;
		error_cnt++;
		test_done;
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, run, gap, l, r, al, ar} = '0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(dac_path_pkg::idx_left_vol, 32'h1ff, 32'h0c0);
		rd(dac_path_pkg::idx_right_vol, 32'h1ff, 32'h0c0);
		rd(dac_path_pkg::idx_sidetone, 32'hfff, 32'h0);
		rd(dac_path_pkg::idx_path_ctrl, 32'h1e0f, 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped", 32'h80000000, {e, q[30:0]});
		{run, gap} <= {1'b1, 4'h3};
		smp(16'h4000, 16'hc000, 16'h0, 16'h0, 16'h4000, 16'hc000);
		wr(dac_path_pkg::idx_left_vol, 32'h0);
		smp(16'h4000, 16'hc000, 16'h0, 16'h0, 16'h4000, 16'hc000);
		wr(dac_path_pkg::idx_right_vol, 32'h1b0);
		smp(16'h4000, 16'hc000, 16'h0, 16'h0, 16'h0, 16'he000);
		rd(dac_path_pkg::idx_right_vol, 32'h1ff, 32'h0b0);
		wr(dac_path_pkg::idx_left_vol, 32'h1c0);
		smp(16'h4000, 16'hc000, 16'h0, 16'h0, 16'h4000, 16'he000);
		wr(dac_path_pkg::idx_right_vol, 32'h1ff);
		wr(dac_path_pkg::idx_sidetone, 32'hc06);
		smp(16'h7000, 16'h0, 16'h7000, 16'h4000, 16'h7fff, 16'h0100);
		smp(16'h9000, 16'h0, 16'h9000, 16'h0, 16'h8000, 16'h0);
		wr(dac_path_pkg::idx_sidetone, 32'hcc9);
		smp(16'h0, 16'h0, 16'h1000, 16'h2000, 16'h2000, 16'h1000);
		wr(dac_path_pkg::idx_sidetone, 32'hcff);
		smp(16'h100, 16'h100, 16'h1000, 16'h2000, 16'h100, 16'h100);
		wr(dac_path_pkg::idx_sidetone, 32'h0);
		wr(dac_path_pkg::idx_path_ctrl, 32'h1000);
		smp(16'h1000, 16'h3000, 16'h0, 16'h0, 16'h2000, 16'h2000);
		wr(dac_path_pkg::idx_path_ctrl, 32'hffff);
		rd(dac_path_pkg::idx_path_ctrl, 32'hffff, 32'h1e0f);
		chk("filter pins", 32'h3, {30'h0, sloping_stopband, osr_double});
		for (int i = 0; i < 4; i++) begin
			wr(dac_path_pkg::idx_path_ctrl, i << 1);
			rd(dac_path_pkg::idx_path_ctrl, 32'hffff, i << 1);
		end
		chk("filter pins", 32'h0, {30'h0, sloping_stopband, osr_double});
		gap <= 4'h0;
		wr(dac_path_pkg::idx_path_ctrl, 32'h8);
		waitn(360);
		rd(dac_path_pkg::idx_status, 32'h600, 32'h200);
		waitn(40);
		rd(dac_path_pkg::idx_status, 32'h7ff, 32'h4c0);
		smp(16'h4000, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h0);
		wr(dac_path_pkg::idx_path_ctrl, 32'h0);
		rd(dac_path_pkg::idx_status, 32'h7ff, 32'h0);
		smp(16'h4000, 16'h4000, 16'h0, 16'h0, 16'h4000, 16'h4000);
		wr(dac_path_pkg::idx_path_ctrl, 32'h408);
		waitn(400);
		rd(dac_path_pkg::idx_status, 32'h600, 32'h200);
		waitn(5800);
		rd(dac_path_pkg::idx_status, 32'h7ff, 32'h4c0);
		wr(dac_path_pkg::idx_path_ctrl, 32'h600);
		waitn(64);
		rd(dac_path_pkg::idx_status, 32'h600, 32'h600);
		test_done;
	end
endmodule
`default_nettype wire
